/* core/ir_pwm_regs.svh */
`ifndef IR_PWM_REGS_SVH
`define IR_PWM_REGS_SVH
// register indices; byte address on the bus is four times the index
`define IDX_CH0_ENABLE 12'h781
`define IDX_CH0_MODE 12'h783
`define IDX_CH0_COMPARE_P 12'h794
`define IDX_CH0_PERIOD_P 12'h796
`define IDX_CH0_PULSE_NUM 12'h7AC
`define IDX_IRQ_MASK_PRI 12'h7B0
`define IDX_IRQ_STATUS_PRI 12'h7B1
`define IDX_IRQ_MASK_SEC 12'h7B2
`define IDX_IRQ_STATUS_SEC 12'h7B3
`define IDX_CH0_COMPARE_A 12'h7C4
`define IDX_CH0_PERIOD_A 12'h7C6
`define IDX_FIFO_ENTRY 12'h7C8
`define IDX_FIFO_STATUS 12'h7CD
`define IDX_FIFO_CLEAR 12'h7CE
`define IDX_FIFO_LEVEL_THR 12'h7CF
// element fields
`define ELEM_COUNT_MSB 13
`define ELEM_SHADOW_BIT 14
`define ELEM_CARRIER_BIT 15
// status bit positions; primary, except the stop bit, which is secondary bit 0
`define IRQ_PNUM_BIT 0
`define IRQ_FIFO_LVL_BIT 1
`define IRQ_FRAME0_BIT 2
`define IRQ_STOP_BIT 0
// fifo size in bytes
`define FIFO_BYTES 8
// reset values
`define RST_PERIOD 16'h0000
`define RST_COMPARE 16'h0000
`define RST_PULSE_NUM 14'h0000
`define RST_MASK 8'h00
`define RST_THRESHOLD 3'h0
`endif

/* core/ir_pwm_pkg.sv */
`default_nettype none
package ir_pwm_pkg;
    typedef enum logic [3:0] {
        MODE_CONTINUOUS = 4'b0000,
        MODE_COUNTING = 4'b0001,
        MODE_REPEAT = 4'b0011,
        MODE_FIFO_CPU = 4'b0111,
        MODE_FIFO_DMA = 4'b1111
    } pwm_mode_e;
endpackage : ir_pwm_pkg
`default_nettype wire

/* core/ir_dma_fifo_pwm_irq.sv */
// Overview of operation
// - element bits 13:0 count, bit 14 shadow set, bit 15 carrier or low.
// - element fifo holds eight bytes, four elements.
// - rising DMA channel enable in DMA mode sets channel 0 enable bit.
// - elements played in order; enable cleared by hardware when fifo runs dry.
// - end of fifo transmission with fifo empty sets secondary status bit 0.
// - stop event raises interrupt only while secondary mask bit 0 is one.
// - status flags cleared only by writing one; hardware never clears them.
// - nine interrupt sources in total.
// - channels 0 to 5 flag frame done at each frame end.
// - counting and repeat modes flag pulse-group done per group.
// - cpu fifo mode flags level below threshold and stop on empty.
// - DMA mode stop flag waits for DMA done, fifo empty, last wave sent.
// - eight mask bits primary, one secondary; source passes when mask one.
// - pending in eight primary status bits and secondary bit 0.
//
// Chosen here: the Avalon-MM interface to the registers.
`include "ir_pwm_regs.svh"
`default_nettype none
module ir_dma_fifo_pwm_irq #(
    parameter int DEPTH = `FIFO_BYTES / 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic dma_ch_enable,
    input wire logic dma_done,
    input wire logic dma_valid,
    input wire logic [15:0] dma_elem,
    output logic dma_ready,
    input wire logic [4:0] frame_done_ext,
    output logic pwm_out,
    output logic irq
);
    localparam int PW = $clog2(DEPTH);

    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire srst_n = rst_s2_q;

    // bus: one wait cycle, the access completes on the edge waitrequest is low
    logic wait_q;
    logic [31:0] rdata_q;
    wire [11:0] idx = avs_address[13:2];
    wire wr_go = !wait_q && avs_write && avs_byteenable[0];
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction : hit

    // per-register write strobes, valid only on the completing edge
    wire enable_wr = wr_go && hit(idx, `IDX_CH0_ENABLE);
    wire mode_wr = wr_go && hit(idx, `IDX_CH0_MODE);
    wire cmp_p_wr = wr_go && hit(idx, `IDX_CH0_COMPARE_P);
    wire per_p_wr = wr_go && hit(idx, `IDX_CH0_PERIOD_P);
    wire cmp_a_wr = wr_go && hit(idx, `IDX_CH0_COMPARE_A);
    wire per_a_wr = wr_go && hit(idx, `IDX_CH0_PERIOD_A);
    wire pnum_wr = wr_go && hit(idx, `IDX_CH0_PULSE_NUM);
    wire mask_p_wr = wr_go && hit(idx, `IDX_IRQ_MASK_PRI);
    wire stat_p_wr = wr_go && hit(idx, `IDX_IRQ_STATUS_PRI);
    wire mask_s_wr = wr_go && hit(idx, `IDX_IRQ_MASK_SEC);
    wire stat_s_wr = wr_go && hit(idx, `IDX_IRQ_STATUS_SEC);
    wire entry_wr = wr_go && hit(idx, `IDX_FIFO_ENTRY);
    wire clear_wr = wr_go && hit(idx, `IDX_FIFO_CLEAR);
    wire thr_wr = wr_go && hit(idx, `IDX_FIFO_LEVEL_THR);

    logic en_q;
    logic dma_en_prev_q;
    logic busy_q;
    logic carrier_q;
    logic shadow_q;
    logic pwm_q;
    logic irq_q;
    logic dma_ready_q;
    logic [3:0] mode_q;
    logic [15:0] cmp_p_q;
    logic [15:0] per_p_q;
    logic [15:0] cmp_a_q;
    logic [15:0] per_a_q;
    logic [15:0] frm_q;
    logic [13:0] pnum_q;
    logic [13:0] grp_q;
    logic [7:0] mask_p_q;
    logic [7:0] stat_p_q;
    logic mask_s_q;
    logic stat_s_q;
    logic [2:0] thr_q;
    logic [15:0] mem [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;

    wire m_dma = mode_q == ir_pwm_pkg::MODE_FIFO_DMA;
    wire m_cpu = mode_q == ir_pwm_pkg::MODE_FIFO_CPU;
    wire m_fifo = m_dma || m_cpu;
    wire m_cont = mode_q == ir_pwm_pkg::MODE_CONTINUOUS;
    wire m_grp = mode_q == ir_pwm_pkg::MODE_COUNTING || mode_q == ir_pwm_pkg::MODE_REPEAT;
    wire empty = cnt_q == '0;
    wire full = cnt_q == (PW + 1)'(DEPTH);

    // frame timing; shadow element picks the alternate pair
    wire [15:0] per_sel = shadow_q ? per_a_q : per_p_q;
    wire [15:0] cmp_sel = shadow_q ? cmp_a_q : cmp_p_q;
    wire frame_end = en_q && busy_q && ({1'b0, frm_q} + 17'h00001 >= {1'b0, per_sel});
    wire last_frame = frame_end && !m_cont && grp_q <= 14'h0001;
    wire group_free = !busy_q || last_frame;
    wire load = en_q && group_free && (m_fifo ? !empty : !(m_grp && last_frame
        && mode_q == ir_pwm_pkg::MODE_COUNTING));
    wire pop = load && m_fifo;
    wire [15:0] head = m_fifo ? mem[rp_q] : {1'b1, 1'b0, pnum_q};
    // the stop waits for an idle cycle so the final frame is fully out
    wire fifo_stop = en_q && m_fifo && !busy_q && empty && (!m_dma || dma_done);
    wire cnt_stop = last_frame && mode_q == ir_pwm_pkg::MODE_COUNTING;

    // fifo writers: DMA in DMA mode, the entry register in cpu mode
    wire push_dma = m_dma && dma_valid && dma_ready_q;
    wire push_cpu = m_cpu && entry_wr && !full;
    wire push = push_dma || push_cpu;
    wire [15:0] push_data = push_dma ? dma_elem : avs_writedata[15:0];
    // clearing during transmission would tear a group, so it is refused
    wire fifo_clr = clear_wr && avs_writedata[0] && !en_q;
    wire [PW:0] cnt_d = fifo_clr ? '0 : cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);

    wire dma_rise = dma_ch_enable && !dma_en_prev_q;
    wire en_d = (fifo_stop || cnt_stop) ? 1'b0 :
        (dma_rise && m_dma) ? 1'b1 :
        enable_wr ? avs_writedata[0] : en_q;

    // interrupt events, set wins over a simultaneous clear
    wire [7:0] ev_p = {frame_done_ext, frame_end,
        m_cpu && ({1'b0, cnt_q} < {1'b0, thr_q}),
        last_frame && m_grp};
    wire ev_s = fifo_stop;
    wire [7:0] clr_p = stat_p_wr ? avs_writedata[7:0] : 8'h00;
    wire clr_s = stat_s_wr && avs_writedata[0];
    logic [7:0] stat_p_d;
    // one flag per source; a clear by a one loses to a same-cycle event
    for (genvar b = 0; b < 8; b++) begin : g_flag
        assign stat_p_d[b] = (stat_p_q[b] && !clr_p[b]) || ev_p[b];
    end
    wire stat_s_d = (stat_s_q & ~clr_s) | ev_s;
    wire irq_d = |(stat_p_d & mask_p_q) || (stat_s_d && mask_s_q);

    wire [31:0] rd_mux =
        hit(idx, `IDX_CH0_ENABLE) ? {31'h0, en_q} :
        hit(idx, `IDX_CH0_MODE) ? {28'h0, mode_q} :
        hit(idx, `IDX_CH0_COMPARE_P) ? {16'h0, cmp_p_q} :
        hit(idx, `IDX_CH0_PERIOD_P) ? {16'h0, per_p_q} :
        hit(idx, `IDX_CH0_COMPARE_A) ? {16'h0, cmp_a_q} :
        hit(idx, `IDX_CH0_PERIOD_A) ? {16'h0, per_a_q} :
        hit(idx, `IDX_CH0_PULSE_NUM) ? {18'h0, pnum_q} :
        hit(idx, `IDX_IRQ_MASK_PRI) ? {24'h0, mask_p_q} :
        hit(idx, `IDX_IRQ_STATUS_PRI) ? {24'h0, stat_p_q} :
        hit(idx, `IDX_IRQ_MASK_SEC) ? {31'h0, mask_s_q} :
        hit(idx, `IDX_IRQ_STATUS_SEC) ? {31'h0, stat_s_q} :
        hit(idx, `IDX_FIFO_STATUS) ? {24'h0, full, empty, 6'(cnt_q)} :
        hit(idx, `IDX_FIFO_LEVEL_THR) ? {29'h0, thr_q} : 32'h0;

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            wait_q <= 1'b1;
        end else if (ce) begin
            wait_q <= !wait_q ? 1'b1 : !(avs_read || avs_write);
        end
    end

    // read data captured in the wait cycle, so it stands on the completing edge
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            rdata_q <= 32'h0;
        end else if (ce && wait_q && avs_read) begin
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            mode_q <= ir_pwm_pkg::MODE_CONTINUOUS;
            cmp_p_q <= `RST_COMPARE;
            per_p_q <= `RST_PERIOD;
            cmp_a_q <= `RST_COMPARE;
            per_a_q <= `RST_PERIOD;
            pnum_q <= `RST_PULSE_NUM;
            mask_p_q <= `RST_MASK;
            mask_s_q <= 1'b0;
            thr_q <= `RST_THRESHOLD;
        end else if (ce) begin
            if (mode_wr) begin
                mode_q <= avs_writedata[3:0];
            end
            if (cmp_p_wr) begin
                cmp_p_q <= avs_writedata[15:0];
            end
            if (per_p_wr) begin
                per_p_q <= avs_writedata[15:0];
            end
            if (cmp_a_wr) begin
                cmp_a_q <= avs_writedata[15:0];
            end
            if (per_a_wr) begin
                per_a_q <= avs_writedata[15:0];
            end
            if (pnum_wr) begin
                pnum_q <= avs_writedata[13:0];
            end
            if (mask_p_wr) begin
                mask_p_q <= avs_writedata[7:0];
            end
            if (mask_s_wr) begin
                mask_s_q <= avs_writedata[0];
            end
            if (thr_wr) begin
                thr_q <= avs_writedata[2:0];
            end
        end
    end

    // fifo storage and pointers
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wp_q] <= push_data;
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            wp_q <= fifo_clr ? '0 : wp_q + PW'(push);
            rp_q <= fifo_clr ? '0 : rp_q + PW'(pop);
            cnt_q <= cnt_d;
        end
    end

    // ready from the next count, so a full fifo never takes one more element
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            dma_ready_q <= 1'b0;
        end else if (ce) begin
            dma_ready_q <= m_dma && (cnt_d < (PW + 1)'(DEPTH));
        end
    end

    // enable and the DMA enable edge detector; idle DMA enable is low
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            en_q <= 1'b0;
            dma_en_prev_q <= 1'b0;
        end else if (ce) begin
            en_q <= en_d;
            dma_en_prev_q <= dma_ch_enable;
        end
    end

    // waveform engine: group sequencer
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            busy_q <= 1'b0;
            carrier_q <= 1'b0;
            shadow_q <= 1'b0;
            grp_q <= 14'h0;
            frm_q <= 16'h0;
        end else if (ce) begin
            if (!en_q) begin
                busy_q <= 1'b0;
            end else if (load) begin
                busy_q <= 1'b1;
                carrier_q <= head[`ELEM_CARRIER_BIT];
                shadow_q <= head[`ELEM_SHADOW_BIT];
                grp_q <= head[`ELEM_COUNT_MSB:0];
                frm_q <= 16'h0;
            end else if (group_free) begin
                busy_q <= 1'b0;
            end else if (frame_end) begin
                frm_q <= 16'h0;
                grp_q <= m_cont ? grp_q : grp_q - 14'h0001;
            end else begin
                frm_q <= frm_q + 16'h0001;
            end
        end
    end

    // disabling drops the output at once; low gaps drive steady low
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            pwm_q <= 1'b0;
        end else if (ce) begin
            pwm_q <= en_d && en_q && busy_q && carrier_q && (frm_q < cmp_sel);
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            stat_p_q <= 8'h00;
            stat_s_q <= 1'b0;
        end else if (ce) begin
            stat_p_q <= stat_p_d;
            stat_s_q <= stat_s_d;
        end
    end

    // irq built from next-state flags, so a clear drops it with the flag
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= irq_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign dma_ready = dma_ready_q;
    assign pwm_out = pwm_q;
    assign irq = irq_q;
endmodule : ir_dma_fifo_pwm_irq
`default_nettype wire

/* verif/ir_dma_fifo_pwm_irq_checker.sv */
`include "ir_pwm_regs.svh"
`default_nettype none
module ir_dma_fifo_pwm_irq_checker #(
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic dma_done,
    input wire logic dma_ready,
    input wire logic [4:0] frame_done_ext,
    input wire logic pwm_out,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mpri_q;
    logic [7:0] msec_q;
    logic [3:0] mode_q;
    wire [11:0] idx = avs_address[13:2];
    wire wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    // shadow copies of mask and mode, the checker cannot see inside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mpri_q <= `RST_MASK;
            msec_q <= `RST_MASK;
            mode_q <= 4'h0;
        end else if (wr_done) begin
            if (idx == `IDX_IRQ_MASK_PRI) mpri_q <= avs_writedata[7:0];
            if (idx == `IDX_IRQ_MASK_SEC) msec_q <= avs_writedata[7:0];
            if (idx == `IDX_CH0_MODE) mode_q <= avs_writedata[3:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
    AST_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_MASK_GATE: assert property ((mpri_q == 8'h00 && msec_q == 8'h00) [*3] |-> !irq)
        else $error("irq high with all sources masked");
    AST_EXT_FRAME: assert property (frame_done_ext[0] && mpri_q[3] |-> ##[1:3] irq)
        else $error("frame done of channel 1 raised no irq");
    AST_STICKY: assert property ($fell(irq) |-> $past(avs_write, 1) || $past(avs_write, 2))
        else $error("irq dropped without a software write");
    AST_READY_MODE: assert property ((mode_q != ir_pwm_pkg::MODE_FIFO_DMA) [*2] |-> !dma_ready)
        else $error("element port ready outside dma mode");
    AST_STOP_DONE: assert property ($rose(irq) && mpri_q == 8'h00 |-> $past(dma_done, 2))
        else $error("stop flag before dma delivered all elements");
    AST_STOP_QUIET: assert property ($rose(irq) && mpri_q == 8'h00 |-> !pwm_out)
        else $error("output still active at stop");
endmodule : ir_dma_fifo_pwm_irq_checker
bind ir_dma_fifo_pwm_irq ir_dma_fifo_pwm_irq_checker #(.DEPTH(DEPTH)) chk (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .dma_done(dma_done), .dma_ready(dma_ready),
    .frame_done_ext(frame_done_ext), .pwm_out(pwm_out), .irq(irq));
`default_nettype wire

/* verif/dma_feed_model.sv */
`default_nettype none
module dma_feed_model (
    input wire logic clk,
    input wire logic dma_ready,
    output logic dma_ch_enable,
    output logic dma_done,
    output logic dma_valid,
    output logic [15:0] dma_elem
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] words [0:7];
    initial begin
        dma_ch_enable = 1'b0;
        dma_done = 1'b0;
        dma_valid = 1'b0;
        dma_elem = 16'hA5C3;
    end
    task automatic send();
        int n;
        n = int'(words[0]) / 2;
        dma_done <= 1'b0;
        dma_ch_enable <= 1'b1;
        for (int k = 0; k < n; k++) begin
            dma_valid <= 1'b1;
            dma_elem <= k[0] ? words[1 + k / 2][31:16] : words[1 + k / 2][15:0];
            @(posedge clk iff dma_ready);
            // random stalls, idle data toggled so stale values never match
            if ($urandom % 2) begin
                dma_valid <= 1'b0;
                dma_elem <= ~dma_elem;
                @(posedge clk);
            end
        end
        dma_valid <= 1'b0;
        dma_elem <= ~dma_elem;
        dma_done <= 1'b1;
        dma_ch_enable <= 1'b0;
    endtask : send
endmodule : dma_feed_model
`default_nettype wire

/* verif/tb_ir_dma_fifo_pwm_irq.sv */
`include "ir_pwm_regs.svh"
`default_nettype none
module tb_ir_dma_fifo_pwm_irq;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq, pwm_out;
    logic dma_ch_enable, dma_done, dma_valid, dma_ready;
    logic [13:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] dma_elem;
    logic [4:0] frame_done_ext;
    logic [31:0] expq [$];
    int failures = 0, comparisons = 0, cyc = 0, highs = 0, exp_highs = 0;
    ir_dma_fifo_pwm_irq uut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dma_ch_enable(dma_ch_enable), .dma_done(dma_done), .dma_valid(dma_valid),
        .dma_elem(dma_elem), .dma_ready(dma_ready), .frame_done_ext(frame_done_ext),
        .pwm_out(pwm_out), .irq(irq));
    dma_feed_model dma (.clk(clk), .dma_ready(dma_ready), .dma_ch_enable(dma_ch_enable),
        .dma_done(dma_done), .dma_valid(dma_valid), .dma_elem(dma_elem));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // expectation queued before the request, popped when read data stand
    task automatic bus(input logic w, input logic [11:0] i, input logic [31:0] d,
                       input logic [31:0] e);
        if (!w) expq.push_back(e);
        avs_address <= {i, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        @(posedge clk iff !avs_waitrequest);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    always @(posedge clk) begin
        cyc++;
        if (pwm_out === 1'b1) highs++;
        if (avs_read && !avs_waitrequest) check(avs_readdata, expq.pop_front(), "rdata");
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end
    // six elements overrun the four-entry fifo, so backpressure is exercised
    task automatic run(input logic [7:0] msec);
        logic [15:0] e;
        dma.words[0] = 32'd12;
        exp_highs = 0;
        for (int k = 0; k < 6; k++) begin
            e = {1'($urandom), 1'($urandom), 12'h000, 2'($urandom % 3) + 2'd1};
            if (e[15]) exp_highs += int'(e[1:0]) * (e[14] ? 3 : 2);
            if (k[0]) dma.words[1 + k / 2][31:16] = e;
            else dma.words[1 + k / 2][15:0] = e;
        end
        bus(1'b1, `IDX_IRQ_MASK_SEC, {24'h0, msec}, 0);
        highs = 0;
        dma.send();
        repeat (300) @(posedge clk);
        check(highs, exp_highs, "carrier");
    endtask : run
    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 14'h0000;
        avs_writedata = 32'h0;
        frame_done_ext = 5'h00;
        void'($urandom(40));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, `IDX_IRQ_MASK_PRI, 0, {24'h0, `RST_MASK});
        bus(1'b1, 12'h7FF, 32'hFF, 0);
        bus(1'b0, 12'h7FF, 0, 0);
        bus(1'b1, `IDX_CH0_PERIOD_P, 4, 0);
        bus(1'b1, `IDX_CH0_COMPARE_P, 2, 0);
        bus(1'b1, `IDX_CH0_PERIOD_A, 6, 0);
        bus(1'b1, `IDX_CH0_COMPARE_A, 3, 0);
        bus(1'b0, `IDX_CH0_PERIOD_A, 0, 6);
        bus(1'b1, `IDX_IRQ_MASK_PRI, 32'hF8, 0);
        for (int i = 0; i < 5; i++) begin
            frame_done_ext <= 5'(1 << i);
            @(posedge clk);
            frame_done_ext <= 5'h00;
            repeat (3) @(posedge clk);
            check(irq, 1, "irq");
            bus(1'b0, `IDX_IRQ_STATUS_PRI, 0, 32'(8 << i));
            bus(1'b1, `IDX_IRQ_STATUS_PRI, 32'(8 << i), 0);
            repeat (2) @(posedge clk);
            check(irq, 0, "irq");
        end
        bus(1'b1, `IDX_IRQ_MASK_PRI, 0, 0);
        bus(1'b1, `IDX_CH0_MODE, {28'h0, ir_pwm_pkg::MODE_FIFO_DMA}, 0);
        run(8'h01);
        check(irq, 1, "irq");
        bus(1'b0, `IDX_IRQ_STATUS_SEC, 0, 1);
        bus(1'b0, `IDX_IRQ_STATUS_PRI, 0, 32'h04);
        bus(1'b0, `IDX_CH0_ENABLE, 0, 0);
        bus(1'b1, `IDX_IRQ_STATUS_SEC, 1, 0);
        run(8'h00);
        check(irq, 0, "irq");
        bus(1'b0, `IDX_IRQ_STATUS_SEC, 0, 1);
        bus(1'b1, `IDX_IRQ_MASK_SEC, 1, 0);
        repeat (2) @(posedge clk);
        check(irq, 1, "irq");
        end_sim();
    end
endmodule : tb_ir_dma_fifo_pwm_irq
`default_nettype wire
